// file: logic/eie_pkg.sv
// Package for the extended-instruction executor: register map, field layout,
// opcodes, flag positions and reset values.
// Assumes a single pclk domain and an APB master with 32-bit data.
package eie_pkg;

   // -------------------------------------------------------------
   // Register byte offsets
   // -------------------------------------------------------------
   localparam logic [7:0] EIE_CMD_OFF = 8'h00;
   localparam logic [7:0] EIE_STAT_OFF = 8'h04;
   localparam logic [7:0] EIE_WORK_OFF = 8'h08;
   localparam logic [7:0] EIE_FLAG_OFF = 8'h0C;
   localparam logic [7:0] EIE_TLP_OFF = 8'h10;
   localparam logic [7:0] EIE_THP_OFF = 8'h14;
   localparam logic [7:0] EIE_THL_OFF = 8'h18;
   localparam logic [7:0] EIE_DMEM_OFF = 8'h40;

   // -------------------------------------------------------------
   // Command word fields
   // -------------------------------------------------------------
   localparam int EIE_CMD_OP_LSB = 0;
   localparam int EIE_CMD_BIT_LSB = 4;
   localparam int EIE_CMD_ADR_LSB = 8;

   // -------------------------------------------------------------
   // Status word fields
   // -------------------------------------------------------------
   localparam int EIE_ST_BUSY = 0;
   localparam int EIE_ST_SKIP = 1;
   localparam int EIE_ST_CYC_LSB = 4;

   // -------------------------------------------------------------
   // Flag bit positions and reset values
   // -------------------------------------------------------------
   localparam int EIE_F_C = 0;
   localparam int EIE_F_AC = 1;
   localparam int EIE_F_Z = 2;
   localparam int EIE_F_OV = 3;
   localparam int EIE_F_SC = 4;
   localparam int EIE_F_CZ = 5;
   localparam logic [5:0] EIE_FLAG_RST = 6'h00;
   localparam logic [7:0] EIE_BYTE_RST = 8'h00;

   // -------------------------------------------------------------
   // Timing in instruction cycles
   // -------------------------------------------------------------
   localparam logic [1:0] EIE_CYC_PLAIN = 2'h2;
   localparam logic [1:0] EIE_CYC_SKIP = 2'h3;

   // -------------------------------------------------------------
   // Opcodes
   // -------------------------------------------------------------
   typedef enum logic [3:0] {
      EIE_OP_SKIP_IF_NONNULL = 4'h0,
      EIE_OP_SUB_TO_WORKING = 4'h1,
      EIE_OP_SUB_TO_MEMORY = 4'h2,
      EIE_OP_NIBBLE_EXCHANGE = 4'h3,
      EIE_OP_NIBBLE_TO_WORKING = 4'h4,
      EIE_OP_SKIP_IF_NULL = 4'h5,
      EIE_OP_SKIP_NULL_MOVE = 4'h6,
      EIE_OP_SKIP_BIT_NULL = 4'h7,
      EIE_OP_TABLE_PAGED = 4'h8,
      EIE_OP_TABLE_FINAL = 4'h9,
      EIE_OP_PREINC_PAGED = 4'hA,
      EIE_OP_PREINC_FINAL = 4'hB,
      EIE_OP_XOR_TO_WORKING = 4'hC,
      EIE_OP_XOR_TO_MEMORY = 4'hD
   } eie_op_e;

   // -------------------------------------------------------------
   // Sequencer states, one-hot
   // -------------------------------------------------------------
   typedef enum logic [3:0] {
      EIE_ST_IDLE = 4'b0001,
      EIE_ST_EXEC = 4'b0010,
      EIE_ST_WB = 4'b0100,
      EIE_ST_DUMMY = 4'b1000
   } eie_state_e;

endpackage

// file: logic/eie_sub_alu.sv
// Subtract unit: working byte minus operand byte with the six arithmetic flags.
// Purely combinational; the caller decides where the difference goes.
`timescale 1ns/1ps
module eie_sub_alu (
   input wire logic [7:0] a,
   input wire logic [7:0] m,
   output logic [7:0] diff,
   output logic [5:0] flags
);
   import eie_pkg::*;

   logic [8:0] wide;
   logic [4:0] low;

   // Borrow-style flags: carry and half flag are set when no borrow occurs
   always_comb begin
      wide = {1'b0, a} - {1'b0, m};
      low = {1'b0, a[3:0]} - {1'b0, m[3:0]};
      diff = wide[7:0];
      flags = 6'h00;
      flags[EIE_F_C] = ~wide[8];
      flags[EIE_F_AC] = ~low[4];
      flags[EIE_F_Z] = (wide[7:0] == 8'h00);
      flags[EIE_F_OV] = (a[7] != m[7]) && (wide[7] != a[7]);
      flags[EIE_F_SC] = ((a[7] != m[7]) && (wide[7] != a[7])) ^ wide[7];
      flags[EIE_F_CZ] = (wide[7:0] == 8'h00);
   end
endmodule

// file: logic/eie_core.sv
// Executor for a subset of extended-address instructions of an 8-bit core:
// subtract, nibble swap, byte and bit skip tests, table reads and XOR.
// Assumes an APB master on pclk and an asynchronous-read program memory
// that returns prog_data in the same cycle prog_addr is presented.
//
// Function
// - Nonzero byte test rewrites byte, skips if nonzero
// - Taken skip adds a dummy third cycle
// - Subtract to working register updates six flags
// - Carry clear on negative, set otherwise
// - Subtract to memory writes difference, same flags
// - Nibble swap in place, flags untouched
// - Nibble swap into working register, memory kept
// - Zero byte test rewrites byte, skips if zero
// - Zero test copies byte to working register
// - Bit test skips when selected bit clear
// - Paged table read uses both pointers
// - Final page table read uses low pointer
// - Paged read increments low pointer first
// - Final page read increments low pointer first
// - XOR into working register, zero flag only
// - XOR into memory, zero flag only
//
// Register access over APB and the address map were decided locally.
`timescale 1ns/1ps
module eie_core #(
   parameter int DMEM_DEPTH = 16,
   parameter int PROG_AW = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic [PROG_AW-1:0] prog_addr,
   input wire logic [15:0] prog_data,
   output logic busy,
   output logic skip_taken
);
   import eie_pkg::*;

   localparam int DIW = $clog2(DMEM_DEPTH);
   localparam int HPW = PROG_AW - 8;

   // -------------------------------------------------------------
   // State
   // -------------------------------------------------------------
   eie_state_e state_q;
   logic [7:0] dmem_q [DMEM_DEPTH];
   logic [7:0] working_register_q;
   logic [5:0] flags_q;
   logic [7:0] table_low_pointer_q;
   logic [7:0] table_high_pointer_q;
   logic [7:0] table_high_latch_q;
   logic [3:0] op_q;
   logic [2:0] bit_q;
   logic [DIW-1:0] idx_q;
   logic skip_q;
   logic [1:0] cyc_q;
   logic pready_q;
   logic pslverr_q;
   logic [31:0] prdata_q;
   logic [PROG_AW-1:0] prog_addr_q;
   logic skip_pulse_q;

   // -------------------------------------------------------------
   // Bus decode
   // -------------------------------------------------------------
   logic setup;
   logic access;
   logic wr;
   logic is_dmem;
   logic [DIW-1:0] bus_idx;
   logic mapped;

   assign setup = psel && !penable;
   assign access = psel && penable && pready_q;
   assign wr = access && pwrite;
   // Data bytes sit one per aligned word above the data-memory base;
   // an offset past the last byte falls through to the error response
   assign is_dmem = (paddr >= EIE_DMEM_OFF) && (paddr[1:0] == 2'h0) &&
                    ({2'h0, paddr[7:2]} - {2'h0, EIE_DMEM_OFF[7:2]} < DMEM_DEPTH);
   assign bus_idx = DIW'({2'h0, paddr[7:2]} - {2'h0, EIE_DMEM_OFF[7:2]});
   assign mapped = is_dmem || paddr == EIE_CMD_OFF || paddr == EIE_STAT_OFF ||
                   paddr == EIE_WORK_OFF || paddr == EIE_FLAG_OFF ||
                   paddr == EIE_TLP_OFF || paddr == EIE_THP_OFF ||
                   paddr == EIE_THL_OFF;

   // -------------------------------------------------------------
   // Execution datapath
   // -------------------------------------------------------------
   logic [7:0] opnd;
   logic [7:0] sub_diff;
   logic [5:0] sub_flags;
   logic [7:0] xor_res;
   logic [7:0] swap_res;
   logic [7:0] tlp_inc;
   logic preinc;
   logic final_pg;
   logic [7:0] tlp_use;
   logic skip_now;
   logic is_table;

   assign opnd = dmem_q[idx_q];
   assign xor_res = working_register_q ^ opnd;
   assign swap_res = {opnd[3:0], opnd[7:4]};
   assign tlp_inc = table_low_pointer_q + 8'h01;
   assign preinc = (op_q == EIE_OP_PREINC_PAGED) || (op_q == EIE_OP_PREINC_FINAL);
   assign final_pg = (op_q == EIE_OP_TABLE_FINAL) || (op_q == EIE_OP_PREINC_FINAL);
   assign tlp_use = preinc ? tlp_inc : table_low_pointer_q;
   // Table opcodes share the top two opcode bits, so one compare selects them
   assign is_table = (op_q[3:2] == 2'b10);

   // One subtractor serves both subtract forms; only the destination of
   // the difference differs between them
   eie_sub_alu u_sub (
      .a(working_register_q),
      .m(opnd),
      .diff(sub_diff),
      .flags(sub_flags)
   );

   // Skip decision taken from the operand as it stands in the execute cycle
   always_comb begin
      skip_now = 1'b0;
      unique case (op_q)
         EIE_OP_SKIP_IF_NONNULL: skip_now = (opnd != 8'h00);
         EIE_OP_SKIP_IF_NULL: skip_now = (opnd == 8'h00);
         EIE_OP_SKIP_NULL_MOVE: skip_now = (opnd == 8'h00);
         EIE_OP_SKIP_BIT_NULL: skip_now = !opnd[bit_q];
         default: skip_now = 1'b0;
      endcase
   end

   // -------------------------------------------------------------
   // Sequencer
   // -------------------------------------------------------------
   // Plain instructions spend two cycles; a taken skip adds the dummy one
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state_q <= EIE_ST_IDLE;
      end else begin
         unique case (state_q)
            EIE_ST_IDLE: begin
               if (wr && paddr == EIE_CMD_OFF) begin
                  state_q <= EIE_ST_EXEC;
               end
            end
            EIE_ST_EXEC: state_q <= EIE_ST_WB;
            EIE_ST_WB: state_q <= skip_q ? EIE_ST_DUMMY : EIE_ST_IDLE;
            EIE_ST_DUMMY: state_q <= EIE_ST_IDLE;
            default: state_q <= EIE_ST_IDLE;
         endcase
      end
   end

   // Latched command; a new command while busy is dropped
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         op_q <= 4'h0;
         bit_q <= 3'h0;
         idx_q <= '0;
      end else if (state_q == EIE_ST_IDLE && wr && paddr == EIE_CMD_OFF) begin
         op_q <= pwdata[EIE_CMD_OP_LSB +: 4];
         bit_q <= pwdata[EIE_CMD_BIT_LSB +: 3];
         idx_q <= pwdata[EIE_CMD_ADR_LSB +: DIW];
      end
   end

   // Skip result and cycle count of the last instruction
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         skip_q <= 1'b0;
         cyc_q <= 2'h0;
         skip_pulse_q <= 1'b0;
      end else begin
         skip_pulse_q <= (state_q == EIE_ST_WB) && skip_q;
         if (state_q == EIE_ST_EXEC) begin
            skip_q <= skip_now;
            cyc_q <= skip_now ? EIE_CYC_SKIP : EIE_CYC_PLAIN;
         end
      end
   end

   // -------------------------------------------------------------
   // Working register and flags
   // -------------------------------------------------------------
   // Software may load them only while the executor is idle
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         working_register_q <= EIE_BYTE_RST;
         flags_q <= EIE_FLAG_RST;
      end else if (state_q == EIE_ST_EXEC) begin
         unique case (op_q)
            EIE_OP_SUB_TO_WORKING: begin
               working_register_q <= sub_diff;
               flags_q <= sub_flags;
            end
            EIE_OP_SUB_TO_MEMORY: flags_q <= sub_flags;
            EIE_OP_NIBBLE_TO_WORKING: working_register_q <= swap_res;
            EIE_OP_SKIP_NULL_MOVE: working_register_q <= opnd;
            EIE_OP_XOR_TO_WORKING: begin
               working_register_q <= xor_res;
               flags_q[EIE_F_Z] <= (xor_res == 8'h00);
            end
            EIE_OP_XOR_TO_MEMORY: flags_q[EIE_F_Z] <= (xor_res == 8'h00);
            default: begin
            end
         endcase
      // Bus loads are gated by idle so hardware and software never race
      end else if (state_q == EIE_ST_IDLE && wr) begin
         if (paddr == EIE_WORK_OFF) begin
            working_register_q <= pwdata[7:0];
         end
         if (paddr == EIE_FLAG_OFF) begin
            flags_q <= pwdata[5:0];
         end
      end
   end

   // -------------------------------------------------------------
   // Table pointers, latch and program address
   // -------------------------------------------------------------
   // Address is set in the execute cycle, the word is taken in write-back
   // High pointer bits above the program address width are ignored
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         table_low_pointer_q <= EIE_BYTE_RST;
         table_high_pointer_q <= EIE_BYTE_RST;
         table_high_latch_q <= EIE_BYTE_RST;
         prog_addr_q <= '0;
      end else if (state_q == EIE_ST_EXEC && is_table) begin
         if (preinc) begin
            table_low_pointer_q <= tlp_inc;
         end
         if (final_pg) begin
            prog_addr_q <= {{HPW{1'b1}}, tlp_use};
         end else begin
            prog_addr_q <= {table_high_pointer_q[HPW-1:0], tlp_use};
         end
      end else if (state_q == EIE_ST_WB && is_table) begin
         table_high_latch_q <= prog_data[15:8];
      end else if (state_q == EIE_ST_IDLE && wr) begin
         if (paddr == EIE_TLP_OFF) begin
            table_low_pointer_q <= pwdata[7:0];
         end
         if (paddr == EIE_THP_OFF) begin
            table_high_pointer_q <= pwdata[7:0];
         end
         if (paddr == EIE_THL_OFF) begin
            table_high_latch_q <= pwdata[7:0];
         end
      end
   end

   // -------------------------------------------------------------
   // Data memory
   // -------------------------------------------------------------
   // The nonzero and zero skip tests read and write back the same value, as the core does
   // A table read lands its low byte one cycle after the address goes out
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         for (int i = 0; i < DMEM_DEPTH; i++) begin
            dmem_q[i] <= EIE_BYTE_RST;
         end
      end else if (state_q == EIE_ST_EXEC) begin
         unique case (op_q)
            EIE_OP_SKIP_IF_NONNULL: dmem_q[idx_q] <= opnd;
            EIE_OP_SKIP_IF_NULL: dmem_q[idx_q] <= opnd;
            EIE_OP_SUB_TO_MEMORY: dmem_q[idx_q] <= sub_diff;
            EIE_OP_NIBBLE_EXCHANGE: dmem_q[idx_q] <= swap_res;
            EIE_OP_XOR_TO_MEMORY: dmem_q[idx_q] <= xor_res;
            default: begin
            end
         endcase
      end else if (state_q == EIE_ST_WB && is_table) begin
         dmem_q[idx_q] <= prog_data[7:0];
      end else if (state_q == EIE_ST_IDLE && wr && is_dmem) begin
         dmem_q[bus_idx] <= pwdata[7:0];
      end
   end

   // -------------------------------------------------------------
   // APB slave
   // -------------------------------------------------------------
   // No wait state: read data is captured in setup so the output is a flop
   // Writes while busy are answered but dropped, so software must poll status
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else begin
         pready_q <= setup;
         pslverr_q <= setup && !mapped;
         prdata_q <= 32'h0000_0000;
         if (setup && !pwrite) begin
            if (is_dmem) begin
               prdata_q <= {24'h00_0000, dmem_q[bus_idx]};
            end else begin
               unique case (paddr)
                  EIE_CMD_OFF: prdata_q <= {16'h0000, {(8-DIW){1'b0}}, idx_q, 1'b0, bit_q, op_q};
                  EIE_STAT_OFF: prdata_q <= {26'h000_0000, cyc_q, 2'h0, skip_q,
                                             state_q != EIE_ST_IDLE};
                  EIE_WORK_OFF: prdata_q <= {24'h00_0000, working_register_q};
                  EIE_FLAG_OFF: prdata_q <= {26'h000_0000, flags_q};
                  EIE_TLP_OFF: prdata_q <= {24'h00_0000, table_low_pointer_q};
                  EIE_THP_OFF: prdata_q <= {24'h00_0000, table_high_pointer_q};
                  EIE_THL_OFF: prdata_q <= {24'h00_0000, table_high_latch_q};
                  default: prdata_q <= 32'h0000_0000;
               endcase
            end
         end
      end
   end

   // -------------------------------------------------------------
   // Outputs
   // -------------------------------------------------------------
   // Busy shows any state other than idle
   // Registered from the next state so it lines up with the sequencer
   logic busy_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         busy_q <= 1'b0;
      end else begin
         busy_q <= (state_q == EIE_ST_IDLE) ? (wr && paddr == EIE_CMD_OFF) :
                   !(state_q == EIE_ST_DUMMY || (state_q == EIE_ST_WB && !skip_q));
      end
   end

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prog_addr = prog_addr_q;
   assign busy = busy_q;
   assign skip_taken = skip_pulse_q;
endmodule

// file: bench/eie_core_monitor.sv
// Checker for the extended-instruction executor: busy and skip timing, and
// table-read program addresses rebuilt from the APB traffic.
// Assumes it is bound to eie_core and that software leaves registers alone while busy.
`timescale 1ns/1ps
module eie_core_monitor
   import eie_pkg::*;
#(
   parameter int DMEM_DEPTH = 16,
   parameter int PROG_AW = 12
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [PROG_AW-1:0] prog_addr,
   input wire logic [15:0] prog_data,
   input wire logic busy,
   input wire logic skip_taken
);
   logic wr_go;
   logic cmd_go;
   logic [3:0] op;
   logic [7:0] tlp_q;
   logic [7:0] thp_q;

   // Committed writes; writes while busy are dropped by the design
   assign wr_go = psel && penable && pready && pwrite && !busy;
   assign cmd_go = wr_go && (paddr == EIE_CMD_OFF);
   assign op = pwdata[3:0];

   // Shadow table pointers, so prog_addr can be predicted without peeking inside
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         tlp_q <= 8'h00;
         thp_q <= 8'h00;
      end else begin
         if (wr_go && paddr == EIE_TLP_OFF) tlp_q <= pwdata[7:0];
         if (wr_go && paddr == EIE_THP_OFF) thp_q <= pwdata[7:0];
         if (cmd_go && (op == 4'hA || op == 4'hB)) tlp_q <= tlp_q + 8'h01;
      end
   end

   // ---------------------------------------------------------------
   // Properties
   // ---------------------------------------------------------------
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_exec_wb;
      busy ##1 busy;
   endsequence
   sequence s_tail;
      (busy == skip_taken) ##1 !busy;
   endsequence
   property p_timing;
      cmd_go |=> s_exec_wb ##1 s_tail;
   endproperty
   a_timing: assert property (p_timing) else $error("busy or skip timing wrong");
   property p_noskip;
      cmd_go && (op > 4'h7 || (op > 4'h0 && op < 4'h5)) |-> ##3 !skip_taken;
   endproperty
   a_noskip: assert property (p_noskip) else $error("skip on a plain op");
   property p_busy_cause;
      $rose(busy) |-> $past(cmd_go);
   endproperty
   a_busy_cause: assert property (p_busy_cause) else $error("busy without command");
   property p_paged;
      cmd_go && op == 4'h8 |-> ##2 prog_addr == {thp_q[PROG_AW-9:0], tlp_q};
   endproperty
   a_paged: assert property (p_paged) else $error("paged table address wrong");
   property p_final;
      cmd_go && op == 4'h9 |-> ##2 prog_addr == {{(PROG_AW-8){1'b1}}, tlp_q};
   endproperty
   a_final: assert property (p_final) else $error("final page address wrong");
   property p_pre_paged;
      cmd_go && op == 4'hA |-> ##2 prog_addr == {thp_q[PROG_AW-9:0], tlp_q};
   endproperty
   a_pre_paged: assert property (p_pre_paged) else $error("preinc paged address wrong");
   property p_pre_final;
      cmd_go && op == 4'hB |-> ##2 prog_addr == {{(PROG_AW-8){1'b1}}, tlp_q};
   endproperty
   a_pre_final: assert property (p_pre_final) else $error("preinc final address wrong");
   property p_tlp_back;
      psel && penable && pready && !pwrite && paddr == EIE_TLP_OFF |-> prdata[7:0] == tlp_q;
   endproperty
   a_tlp_back: assert property (p_tlp_back) else $error("low pointer not stored back");
endmodule

bind eie_core eie_core_monitor #(.DMEM_DEPTH(DMEM_DEPTH), .PROG_AW(PROG_AW)) u_mon (
   .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
   .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .prog_addr(prog_addr), .prog_data(prog_data), .busy(busy), .skip_taken(skip_taken)
);

// file: bench/tb_eie_core.sv
// Self-checking bench for the extended-instruction executor.
// Assumes eie_core with default parameters; the bench models program memory.
`timescale 1ns/1ps
module tb_eie_core;
   import eie_pkg::*;
   logic pclk = 1'b0;
   logic presetn = 1'b0;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready;
   logic pslverr;
   logic [11:0] prog_addr;
   logic [15:0] prog_data;
   logic busy;
   logic skip_taken;
   logic [31:0] rdat;
   logic rerr;
   int num_errors = 0;
   int compares = 0;
   int cycles = 0;
   // Scenario tables: subtract operands, swap/xor cases, skip cases, table reads
   localparam logic [7:0] SA[4] = '{8'h05, 8'h03, 8'h80, 8'h10};
   localparam logic [7:0] SM[4] = '{8'h03, 8'h05, 8'h01, 8'h10};
   localparam logic [55:0] MX[5] = '{56'h03_11_A5_11_5A_2A_2A, 56'h04_11_C3_3C_C3_15_15,
      56'h0C_5A_5A_00_5A_3B_3F, 56'h0D_F0_0F_F0_FF_3F_3B, 56'h0C_01_03_02_03_04_00};
   localparam logic [31:0] SK[10] = '{32'h00000000, 32'h00000101, 32'h05000001, 32'h05008000,
      32'h06000001, 32'h06004200, 32'h0703F701, 32'h07030800, 32'h07077F01, 32'h07000100};
   localparam logic [23:0] TB[5] = '{24'h08FF05, 24'h093405, 24'h0AFF06, 24'h0B7F02, 24'h0A100A};

   eie_core uut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .prog_addr(prog_addr), .prog_data(prog_data), .busy(busy),
      .skip_taken(skip_taken));

   // Program memory answers at once; every address bit shows in the word
   assign prog_data = {4'h9, prog_addr};
   always #4 pclk = ~pclk;

   // ---------------------------------------------------------------
   // Bus and check helpers
   // ---------------------------------------------------------------
   task chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         num_errors++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   // One APB transfer; waits for pready, only the hang guard ends the wait
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task wr(input logic [7:0] a, input logic [7:0] d);
      apb(1'b1, a, {24'h0, d});
   endtask
   task rd_chk(input logic [7:0] a, input logic [7:0] e);
      apb(1'b0, a, 32'h0);
      chk(rdat, {24'h0, e});
   endtask
   function automatic logic [7:0] dm(input int i);
      return EIE_DMEM_OFF + 8'(4 * i);
   endfunction
   task prep(input logic [7:0] a, input logic [7:0] f, input int i, input logic [7:0] m);
      wr(EIE_WORK_OFF, a);
      wr(EIE_FLAG_OFF, f);
      wr(dm(i), m);
   endtask
   // Issue a command and count busy cycles until it drops
   task run(input logic [3:0] op, input logic [2:0] b, input logic [3:0] m, output int cyc,
      output logic sk);
      int n;
      cyc = 0;
      sk = 1'b0;
      n = 0;
      apb(1'b1, EIE_CMD_OFF, {16'h0, 4'h0, m, 1'b0, b, op});
      do begin
         @(posedge pclk);
         n++;
         if (busy === 1'b1) cyc++;
         if (skip_taken === 1'b1) sk = 1'b1;
      end while ((n < 2 || busy !== 1'b0) && n < 10);
   endtask

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   task t_reset;
      rd_chk(EIE_WORK_OFF, 8'h00);
      rd_chk(EIE_FLAG_OFF, 8'h00);
      rd_chk(EIE_THL_OFF, 8'h00);
      rd_chk(dm(0), 8'h00);
      apb(1'b0, 8'h20, 32'h0);
      chk(rerr, 1'b1);
      chk(rdat, 32'h0);
   endtask
   // Flags preset to the inverse so every flag must really be written
   task t_sub;
      logic [7:0] a, m, d;
      logic [5:0] f;
      int cyc;
      logic sk;
      for (int k = 0; k < 8; k++) begin
         a = SA[k % 4];
         m = SM[k % 4];
         d = a - m;
         f[EIE_F_C] = a >= m;
         f[EIE_F_AC] = a[3:0] >= m[3:0];
         f[EIE_F_Z] = d == 8'h00;
         f[EIE_F_OV] = (a[7] != m[7]) && (d[7] != a[7]);
         f[EIE_F_SC] = f[EIE_F_OV] ^ d[7];
         f[EIE_F_CZ] = f[EIE_F_Z];
         prep(a, {2'b00, ~f}, 3, m);
         run(k < 4 ? 4'h1 : 4'h2, 3'h0, 4'h3, cyc, sk);
         rd_chk(EIE_WORK_OFF, k < 4 ? d : a);
         rd_chk(dm(3), k < 4 ? m : d);
         rd_chk(EIE_FLAG_OFF, {2'b00, f});
      end
   endtask
   task t_misc;
      int cyc;
      logic sk;
      for (int k = 0; k < 5; k++) begin
         prep(MX[k][47:40], MX[k][15:8], 9, MX[k][39:32]);
         run(MX[k][51:48], 3'h0, 4'h9, cyc, sk);
         chk(cyc, 2);
         rd_chk(EIE_WORK_OFF, MX[k][31:24]);
         rd_chk(dm(9), MX[k][23:16]);
         rd_chk(EIE_FLAG_OFF, MX[k][7:0]);
      end
   endtask
   // Memory must read back unchanged and flags untouched after every test
   task t_skip;
      int cyc;
      logic sk;
      logic s;
      for (int k = 0; k < 10; k++) begin
         s = SK[k][0];
         prep(8'hEE, 8'h2D, 5, SK[k][15:8]);
         run(SK[k][27:24], SK[k][18:16], 4'h5, cyc, sk);
         chk(cyc, s ? 3 : 2);
         chk(sk, s);
         rd_chk(EIE_STAT_OFF, {s ? 2'h3 : 2'h2, 2'b00, s, 1'b0});
         rd_chk(dm(5), SK[k][15:8]);
         rd_chk(EIE_WORK_OFF, SK[k][27:24] == 4'h6 ? SK[k][15:8] : 8'hEE);
         rd_chk(EIE_FLAG_OFF, 8'h2D);
      end
   endtask
   task t_table;
      int cyc;
      logic sk;
      logic [7:0] nt;
      logic [15:0] w;
      for (int k = 0; k < 5; k++) begin
         nt = TB[k][17] ? TB[k][15:8] + 8'h01 : TB[k][15:8];
         w = {4'h9, TB[k][16] ? 4'hF : TB[k][3:0], nt};
         prep(8'h00, 8'h11, 7, 8'hAA);
         wr(EIE_TLP_OFF, TB[k][15:8]);
         wr(EIE_THP_OFF, TB[k][7:0]);
         run(TB[k][19:16], 3'h0, 4'h7, cyc, sk);
         rd_chk(dm(7), w[7:0]);
         rd_chk(EIE_THL_OFF, w[15:8]);
         rd_chk(EIE_TLP_OFF, nt);
         rd_chk(EIE_FLAG_OFF, 8'h11);
      end
   endtask

   task report_and_stop;
      $display("mismatches %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   // Hang guard, far above the fewer than a thousand cycles the run needs
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         num_errors++;
         report_and_stop;
      end
   end

   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      t_reset;
      t_sub;
      t_misc;
      t_skip;
      t_table;
      report_and_stop;
   end
endmodule
